// *** core/sbm_regs.svh ***
// register offsets, field positions and reset values of the bus-condition port
// ****************************************************************************
// How it works
// R1: port works only while enable bit set
// R2: reset or disable clears start/stop flags
// R3: start sets start, clears stop; vice versa
// R4: firmware claims bus after stop or idle
// R5: cleared direction bit drives pin low
// R6: firmware sends bits via direction bits
// R7: start, stop, byte set port event flag
// R8: mode 1011 is firmware master, slave idle; mode bits are not decoded, so the slave keeps receiving
// R9: firmware sorts interrupt source when mixed
// R10: interrupt enabled while busy fires at stop
// R11: firmware checks data line when outputting high
// R12: lost arbitration: firmware releases both lines
// R13: data-stage loss means firmware retries later
// R14: slave keeps receiving after lost arbitration
// R15: registers reset to zero, direction to ones; the rx/tx buffer is not reset
// R16: sample and edge bits read zero here
// R17: unused flag and enable bits read zero
// R18: start/stop seen on synced data edge, clock high
// ****************************************************************************
`ifndef SBM_REGS_SVH
`define SBM_REGS_SVH

// register offsets
`define SBM_OFS_IRQ_FLAGS   8'h0c
`define SBM_OFS_RX_TX_BUF   8'h13
`define SBM_OFS_CONTROL     8'h14
`define SBM_OFS_DIRECTION   8'h87
`define SBM_OFS_IRQ_ENABLES 8'h8c
`define SBM_OFS_OWN_ADDR    8'h93
`define SBM_OFS_STATUS      8'h94
`define SBM_OFS_COND_FLAGS  8'ha0
`define SBM_OFS_COND_MASK   8'ha1

// field positions
`define SBM_CTL_ENABLE      5
`define SBM_STAT_STOP       4
`define SBM_STAT_START      3
`define SBM_IRQ_PORT_EVENT  3
`define SBM_DIR_DATA        4
`define SBM_DIR_CLOCK       3
`define SBM_COND_START      0
`define SBM_COND_STOP       1
`define SBM_COND_BYTE       2

// writable masks, reset values, master mode code and byte edge count
`define SBM_IRQ_IMPL_MASK   8'h4f
`define SBM_STAT_SW_MASK    8'h27
`define SBM_COND_MASK_BITS  8'h07
`define SBM_RST_ZERO        8'h00
`define SBM_RST_DIRECTION   8'hff
`define SBM_MODE_FW_MASTER  4'hb
`define SBM_BYTE_EDGES      4'h9

`endif

// *** core/sbm_pkg.sv ***
// types shared by the bus-condition port
package sbm_pkg;
   // byte counter states
   typedef enum logic [1:0] {
      SBM_IDLE,
      SBM_COUNT,
      SBM_DONE
   } sbm_byte_state_t;
endpackage

// *** core/sbm_sync.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sbm_sync (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic clk_en,
   // pin in, filtered level out
   input  wire logic pin_in,
   output logic      level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // first stage read only by second; level moves once stages agree
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         level  <= 1'b1;
      end else if (clk_en) begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level <= s3_reg;
         end
      end
   end
endmodule // sbm_sync

// *** core/sbm_cond_detect.sv ***
// start and stop detector on synchronised bus lines
`timescale 1ns/1ps
module sbm_cond_detect (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic clk_en,
   // synchronised lines
   input  wire logic scl_level,
   input  wire logic sda_level,
   // one-cycle events
   output logic      start_pulse,
   output logic      stop_pulse,
   output logic      scl_rise,
   output logic      scl_fall
);
   logic scl_prev_reg;
   logic sda_prev_reg;

   // previous levels for edge finding
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else if (clk_en) begin
         scl_prev_reg <= scl_level;
         sda_prev_reg <= sda_level;
      end
   end

   // R18: data edges while clock high
   assign start_pulse = clk_en & scl_level & scl_prev_reg
                      & sda_prev_reg & ~sda_level;
   assign stop_pulse  = clk_en & scl_level & scl_prev_reg
                      & ~sda_prev_reg & sda_level;
   assign scl_rise    = clk_en & scl_level & ~scl_prev_reg;
   assign scl_fall    = clk_en & ~scl_level & scl_prev_reg;
endmodule // sbm_cond_detect

// *** core/sbm_port.sv ***
// two-wire bus-condition port with firmware master support
//
// The address-and-strobe port was decided locally.
`include "sbm_regs.svh"
`timescale 1ns/1ps
module sbm_port (
   // clock, enable, reset
   input  wire logic       clk_sys,
   input  wire logic       clk_en,
   input  wire logic       reset,
   input  wire logic       power_on_reset,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // bus clock line
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   // bus data line
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // interrupts
   output logic            port_irq,
   output logic            cond_irq
);
   // ************************************************************************
   // registers
   // ************************************************************************
   logic [7:0] peripheral_irq_flags_reg;
   logic [7:0] peripheral_irq_enables_reg;
   logic [7:0] serial_rx_tx_buffer_reg;
   logic [7:0] serial_port_control_reg;
   logic [7:0] port_c_direction_reg;
   logic [7:0] port_c_output_latch_reg;
   logic [7:0] own_bus_address_reg;
   logic [7:0] serial_port_status_reg;
   logic [7:0] cond_flags_reg;
   logic [7:0] cond_mask_reg;
   logic [3:0] bit_count_reg;
   logic [7:0] shift_reg;
   sbm_pkg::sbm_byte_state_t byte_state_reg;

   logic       scl_level;
   logic       sda_level;
   logic       start_pulse;
   logic       stop_pulse;
   logic       scl_rise;
   logic       scl_fall;
   logic       port_on;
   logic       byte_done;
   logic       wr_ok;
   logic [7:0] cond_set;
   logic [3:0] port_mode_select;

   // write hit helper, used for every register
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   assign wr_ok            = clk_en & reg_wr;
   assign port_mode_select = serial_port_control_reg[3:0];
   // R1: condition, byte and start/stop status logic gated by enable bit
   assign port_on = serial_port_control_reg[`SBM_CTL_ENABLE];

   // ************************************************************************
   // line sampling
   // ************************************************************************
   sbm_sync u_sync_scl (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .pin_in  (scl_in),
      .level   (scl_level)
   );

   sbm_sync u_sync_sda (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .pin_in  (sda_in),
      .level   (sda_level)
   );

   sbm_cond_detect u_detect (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .clk_en      (clk_en),
      .scl_level   (scl_level),
      .sda_level   (sda_level),
      .start_pulse (start_pulse),
      .stop_pulse  (stop_pulse),
      .scl_rise    (scl_rise),
      .scl_fall    (scl_fall)
   );

   // ************************************************************************
   // byte tracking
   // ************************************************************************
   // counts clock rises after start; the fall after the ninth rise ends
   // a byte, so the fall that closes the start is never taken as a bit.
   // the slave side keeps receiving whatever the firmware master does,
   // so a lost arbitration does not stop the shift.
   // R14: receive continues independent of master
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         byte_state_reg <= sbm_pkg::SBM_IDLE;
         bit_count_reg  <= 4'h0;
         shift_reg      <= 8'h00;
      end else if (clk_en) begin
         if (!port_on || stop_pulse) begin
            byte_state_reg <= sbm_pkg::SBM_IDLE;
            bit_count_reg  <= 4'h0;
         end else if (start_pulse) begin
            byte_state_reg <= sbm_pkg::SBM_COUNT;
            bit_count_reg  <= 4'h0;
         end else begin
            case (byte_state_reg)
               sbm_pkg::SBM_IDLE: begin
                  bit_count_reg <= 4'h0;
               end
               sbm_pkg::SBM_COUNT: begin
                  // eight data rises shift, the ninth is the acknowledge
                  if (scl_rise && bit_count_reg != `SBM_BYTE_EDGES) begin
                     if (bit_count_reg != `SBM_BYTE_EDGES - 4'h1) begin
                        shift_reg <= {shift_reg[6:0], sda_level};
                     end
                     bit_count_reg <= bit_count_reg + 4'h1;
                  end
                  if (scl_fall && bit_count_reg == `SBM_BYTE_EDGES) begin
                     byte_state_reg <= sbm_pkg::SBM_DONE;
                  end
               end
               sbm_pkg::SBM_DONE: begin
                  byte_state_reg <= sbm_pkg::SBM_COUNT;
                  bit_count_reg  <= 4'h0;
               end
               default: begin
                  byte_state_reg <= sbm_pkg::SBM_IDLE;
               end
            endcase
         end
      end
   end

   // one-cycle mark of a completed byte
   assign byte_done = (byte_state_reg == sbm_pkg::SBM_DONE);

   // received byte lands in the buffer; kept across warm resets
   always_ff @(posedge clk_sys) begin
      if (clk_en && !reset) begin
         if (wr_ok && hit(reg_addr, `SBM_OFS_RX_TX_BUF)) begin
            serial_rx_tx_buffer_reg <= reg_wdata;
         end else if (byte_done && port_on) begin
            serial_rx_tx_buffer_reg <= shift_reg;
         end
      end
   end

   // ************************************************************************
   // control, address, direction, latch
   // ************************************************************************
   // R15: zero control and address, all-ones direction
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         serial_port_control_reg <= `SBM_RST_ZERO;
         own_bus_address_reg     <= `SBM_RST_ZERO;
         port_c_direction_reg    <= `SBM_RST_DIRECTION;
         port_c_output_latch_reg <= `SBM_RST_ZERO;
      end else if (wr_ok) begin
         if (hit(reg_addr, `SBM_OFS_CONTROL)) begin
            serial_port_control_reg <= reg_wdata;
         end
         if (hit(reg_addr, `SBM_OFS_OWN_ADDR)) begin
            own_bus_address_reg <= reg_wdata;
         end
         if (hit(reg_addr, `SBM_OFS_DIRECTION)) begin
            port_c_direction_reg <= reg_wdata;
         end
      end
   end

   // ************************************************************************
   // status flags
   // ************************************************************************
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         serial_port_status_reg <= `SBM_RST_ZERO;
      end else if (clk_en) begin
         if (wr_ok && hit(reg_addr, `SBM_OFS_STATUS)) begin
            // R16: sample and edge bits stay zero
            serial_port_status_reg[7:6] <= 2'b00;
            serial_port_status_reg[5] <= reg_wdata[5];
            serial_port_status_reg[2:0] <= reg_wdata[2:0];
         end
         if (!port_on) begin
            // R2: disable clears start and stop
            serial_port_status_reg[`SBM_STAT_START] <= 1'b0;
            serial_port_status_reg[`SBM_STAT_STOP]  <= 1'b0;
         end else if (start_pulse) begin
            // R3: start sets start, clears stop
            serial_port_status_reg[`SBM_STAT_START] <= 1'b1;
            serial_port_status_reg[`SBM_STAT_STOP]  <= 1'b0;
         end else if (stop_pulse) begin
            serial_port_status_reg[`SBM_STAT_START] <= 1'b0;
            serial_port_status_reg[`SBM_STAT_STOP]  <= 1'b1;
         end
      end
   end

   // ************************************************************************
   // interrupt flags and enables
   // ************************************************************************
   // mode 1011 and slave modes both raise events; source sorting is
   // left to firmware through the condition flag register
   // R8: master support in every mode
   assign cond_set = {5'h00, byte_done, stop_pulse, start_pulse}
                   & {8{port_on}};

   // R7: start, stop, byte raise port event
   // R10: stop while busy fires when enabled
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         peripheral_irq_flags_reg <= `SBM_RST_ZERO;
      end else if (clk_en) begin
         if (wr_ok && hit(reg_addr, `SBM_OFS_IRQ_FLAGS)) begin
            peripheral_irq_flags_reg <= reg_wdata & `SBM_IRQ_IMPL_MASK;
         end
         // set wins over a same-cycle write
         if (|cond_set) begin
            peripheral_irq_flags_reg[`SBM_IRQ_PORT_EVENT] <= 1'b1;
         end
      end
   end

   // R17: unused enable bits read zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         peripheral_irq_enables_reg <= `SBM_RST_ZERO;
      end else if (wr_ok && hit(reg_addr, `SBM_OFS_IRQ_ENABLES)) begin
         peripheral_irq_enables_reg <= reg_wdata & `SBM_IRQ_IMPL_MASK;
      end
   end

   // R9: per-source sticky flags, write one to clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cond_flags_reg <= `SBM_RST_ZERO;
         cond_mask_reg  <= `SBM_RST_ZERO;
      end else if (clk_en) begin
         if (wr_ok && hit(reg_addr, `SBM_OFS_COND_FLAGS)) begin
            cond_flags_reg <= (cond_flags_reg & ~reg_wdata) | cond_set;
         end else begin
            cond_flags_reg <= cond_flags_reg | cond_set;
         end
         if (wr_ok && hit(reg_addr, `SBM_OFS_COND_MASK)) begin
            cond_mask_reg <= reg_wdata & `SBM_COND_MASK_BITS;
         end
      end
   end

   // interrupt outputs from flops
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         port_irq <= 1'b0;
         cond_irq <= 1'b0;
      end else if (clk_en) begin
         port_irq <= |(peripheral_irq_flags_reg
                       & peripheral_irq_enables_reg);
         cond_irq <= |(cond_flags_reg & cond_mask_reg);
      end
   end

   // ************************************************************************
   // pin drive
   // ************************************************************************
   // open drain: output is always low, only the enable follows the
   // direction bit; the latch value is ignored on purpose
   // R5: cleared direction bit pulls low
   // R6: firmware toggles direction for data
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else if (clk_en) begin
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         scl_oe_n <= port_c_direction_reg[`SBM_DIR_CLOCK];
         sda_oe_n <= port_c_direction_reg[`SBM_DIR_DATA];
      end
   end

   // ************************************************************************
   // read port
   // ************************************************************************
   // read data valid in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `SBM_OFS_IRQ_FLAGS:   reg_rdata <= peripheral_irq_flags_reg;
               `SBM_OFS_RX_TX_BUF:   reg_rdata <= serial_rx_tx_buffer_reg;
               `SBM_OFS_CONTROL:     reg_rdata <= serial_port_control_reg;
               `SBM_OFS_DIRECTION:   reg_rdata <= port_c_direction_reg;
               `SBM_OFS_IRQ_ENABLES: reg_rdata <= peripheral_irq_enables_reg;
               `SBM_OFS_OWN_ADDR:    reg_rdata <= own_bus_address_reg;
               `SBM_OFS_STATUS:      reg_rdata <= serial_port_status_reg;
               `SBM_OFS_COND_FLAGS:  reg_rdata <= cond_flags_reg;
               `SBM_OFS_COND_MASK:   reg_rdata <= cond_mask_reg;
               default:              reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // sbm_port

// *** verification/sbm_port_sva.sv ***
// assertions on the pins of the bus-condition port
`timescale 1ns/1ps
module sbm_port_sva (
   // clock and resets
   input wire logic       clk_sys,
   input wire logic       clk_en,
   input wire logic       reset,
   input wire logic       power_on_reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // bus lines
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe_n,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   // interrupts
   input wire logic       port_irq,
   input wire logic       cond_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [3:0] quiet_reg;

   // cycles since a write or line change; an irq needs a recent cause
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         quiet_reg <= 4'h0;
      else if (reg_wr || $changed(scl_in) || $changed(sda_in))
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf)
         quiet_reg <= quiet_reg + 4'h1;
   end

   AST_OUT_LOW: assert property (!scl_out && !sda_out)
      else $error("pin output level not low");
   AST_DIR_DATA: assert property (reg_wr && reg_addr == 8'h87 |->
      ##2 sda_oe_n == $past(reg_wdata[4], 2))
      else $error("data line enable does not follow direction");
   AST_DIR_CLOCK: assert property (reg_wr && reg_addr == 8'h87 |->
      ##2 scl_oe_n == $past(reg_wdata[3], 2))
      else $error("clock line enable does not follow direction");
   AST_DIR_RESET: assert property ($fell(reset) |-> scl_oe_n && sda_oe_n)
      else $error("lines driven right after reset");
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside a read answer");
   AST_IRQ_RSVD: assert property (reg_rd &&
      (reg_addr == 8'h0c || reg_addr == 8'h8c) |=> (reg_rdata & 8'hb0) == 8'h00)
      else $error("unused flag or enable bit reads one");
   AST_STAT_VARIANT: assert property (reg_rd && reg_addr == 8'h94 |=>
      reg_rdata[7:6] == 2'b00)
      else $error("sample or edge bit reads one");
   AST_IRQ_CAUSE: assert property ($rose(port_irq) || $rose(cond_irq)
      |-> quiet_reg < 4'hc)
      else $error("interrupt raised with no recent cause");
   AST_IRQ_DROP: assert property ($fell(port_irq) |-> $past(reg_wr, 2))
      else $error("port interrupt dropped without a write");
   AST_COND_DROP: assert property ($fell(cond_irq) |-> $past(reg_wr, 2))
      else $error("condition interrupt dropped without a write");

   // main scenarios reached
   cover property ($rose(port_irq));
   cover property ($rose(cond_irq));
   cover property ($fell(sda_oe_n));
endmodule // sbm_port_sva

// *** verification/sbm_bus_model.sv ***
// other master and slaves sharing the two-wire bus
`timescale 1ns/1ps
module sbm_bus_model #(
   parameter int HALF_NS = 100
) (
   // clock used only to keep edges off the sampling edge
   input wire logic clk_sys,
   // high lets the pull-up win, low pulls the line down
   output logic     scl_rel,
   output logic     sda_rel
);
   // idle bus: both released, link clock stands still
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end

   // start only from an idle or stopped bus
   task automatic start_cond();
      @(posedge clk_sys);
      #7;
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      #HALF_NS;
      sda_rel = 1'b0;
      #HALF_NS;
      scl_rel = 1'b0;
      #(2 * HALF_NS);
   endtask

   // one by releasing data, zero by pulling it low
   task automatic send_byte(input logic [7:0] data);
      @(posedge clk_sys);
      #7;
      for (int i = 7; i >= 0; i--) begin
         sda_rel = data[i];
         #HALF_NS;
         scl_rel = 1'b1;
         #HALF_NS;
         scl_rel = 1'b0;
      end
      // ninth clock with data released, nobody acknowledges
      sda_rel = 1'b1;
      #HALF_NS;
      scl_rel = 1'b1;
      #HALF_NS;
      scl_rel = 1'b0;
      #(2 * HALF_NS);
   endtask

   // stop, then both lines left released
   task automatic stop_cond();
      @(posedge clk_sys);
      #7;
      sda_rel = 1'b0;
      #HALF_NS;
      scl_rel = 1'b1;
      #HALF_NS;
      sda_rel = 1'b1;
      #(2 * HALF_NS);
   endtask
endmodule // sbm_bus_model

// *** verification/sbm_port_test.sv ***
// self-checking bench of the bus-condition port
`timescale 1ns/1ps
module sbm_port_test;
   logic       clk_sys = 1'b0;
   logic       reset = 1'b1;
   logic       clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic       port_irq, cond_irq, scl_rel, sda_rel;
   int         bad_count = 0;
   int         checked = 0;
   int         cycles = 0;
   logic [7:0] addr_tab [7] = '{8'h0c, 8'h14, 8'h87, 8'h8c, 8'h93, 8'h94, 8'h55};
   logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   // wired-and lines with pull-ups
   wire        scl_line = (scl_oe_n | scl_out) & scl_rel;
   wire        sda_line = (sda_oe_n | sda_out) & sda_rel;

   always #12.5 clk_sys = ~clk_sys;

   sbm_port dut (
      .clk_sys(clk_sys), .clk_en(clk_en), .reset(reset),
      .power_on_reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .port_irq(port_irq), .cond_irq(cond_irq));
   sbm_bus_model #(.HALF_NS(100)) model (
      .clk_sys(clk_sys), .scl_rel(scl_rel), .sda_rel(sda_rel));

   // counts and closes the run
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk8(what, {7'h00, exp}, {7'h00, got});
   endtask

   // one-cycle strobes launched right after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk8($sformatf("reg %h", a), exp, reg_rdata);
   endtask

   // let a write reach the registered pins
   task automatic settle();
      repeat (8) @(posedge clk_sys);
      #1;
   endtask

   // hang guard, far above the few hundred cycles needed
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (addr_tab[i])
         rd(addr_tab[i], rst_tab[i]);
      chk1("sda_oe_n", 1'b1, sda_oe_n);
      // a write while the clock enable is low is lost
      clk_en <= 1'b0;
      wr(8'h8c, 8'h08);
      clk_en <= 1'b1;
      rd(8'h8c, 8'h00);
      // unused and read-only bits, irq from a set flag
      wr(8'h0c, 8'hff);
      wr(8'h8c, 8'hff);
      wr(8'h94, 8'hff);
      rd(8'h0c, 8'h4f);
      rd(8'h8c, 8'h4f);
      rd(8'h94, 8'h27);
      chk1("port_irq", 1'b1, port_irq);
      wr(8'h0c, 8'h00);
      wr(8'h8c, 8'h00);
      wr(8'h94, 8'h00);
      settle();
      chk1("port_irq", 1'b0, port_irq);
      // direction bits against the pins and wire
      wr(8'h87, 8'hef);
      settle();
      chk1("sda_oe_n", 1'b0, sda_oe_n);
      chk1("sda_line", 1'b0, sda_line);
      chk1("scl_oe_n", 1'b1, scl_oe_n);
      wr(8'h87, 8'hff);
      wr(8'h87, 8'hf7);
      settle();
      chk1("scl_oe_n", 1'b0, scl_oe_n);
      wr(8'h87, 8'hff);
      // bus conditions while the port is off
      model.start_cond();
      model.stop_cond();
      rd(8'h94, 8'h00);
      rd(8'h0c, 8'h00);
      // enabled in firmware master mode
      wr(8'h14, 8'h2b);
      rd(8'h14, 8'h2b);
      wr(8'h8c, 8'h08);
      wr(8'ha1, 8'h07);
      rd(8'h94, 8'h00);
      model.start_cond();
      rd(8'h94, 8'h08);
      rd(8'h0c, 8'h08);
      rd(8'ha0, 8'h01);
      chk1("port_irq", 1'b1, port_irq);
      chk1("cond_irq", 1'b1, cond_irq);
      wr(8'h0c, 8'h00);
      wr(8'ha0, 8'h07);
      model.send_byte(8'ha5);
      rd(8'h13, 8'ha5);
      rd(8'ha0, 8'h04);
      rd(8'h0c, 8'h08);
      // enable the irq while busy, then stop
      wr(8'h8c, 8'h00);
      wr(8'h0c, 8'h00);
      wr(8'h8c, 8'h08);
      settle();
      chk1("port_irq", 1'b0, port_irq);
      model.stop_cond();
      chk1("port_irq", 1'b1, port_irq);
      rd(8'h94, 8'h10);
      rd(8'ha0, 8'h06);
      // own start and stop through the direction bit
      wr(8'h87, 8'hef);
      settle();
      rd(8'h94, 8'h08);
      wr(8'h87, 8'hff);
      settle();
      rd(8'h94, 8'h10);
      chk1("sda_line", 1'b1, sda_line);
      // another master wins while we leave data high
      model.start_cond();
      chk1("sda_line", 1'b0, sda_line);
      wr(8'h87, 8'hff);
      model.stop_cond();
      rd(8'h94, 8'h10);
      // retry once the bus is free again
      wr(8'h87, 8'hef);
      settle();
      rd(8'h94, 8'h08);
      wr(8'h87, 8'hff);
      settle();
      rd(8'h94, 8'h10);
      wr(8'h14, 8'h00);
      rd(8'h94, 8'h00);
      // second reset with the bus busy
      wr(8'h14, 8'h2b);
      model.start_cond();
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rd(8'h94, 8'h00);
      rd(8'h87, 8'hff);
      rd(8'h14, 8'h00);
      model.stop_cond();
      print_verdict();
   end
endmodule // sbm_port_test

bind sbm_port sbm_port_sva chk (
   .clk_sys(clk_sys), .clk_en(clk_en), .reset(reset),
   .power_on_reset(power_on_reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .port_irq(port_irq), .cond_irq(cond_irq));
